// file: rtl/adcctl_params.svh
// Register offsets, field positions, reset values and timing counts of the converter control block.
// Assumes inclusion by bare name from files compiled under rtl/.
`ifndef ADCCTL_PARAMS_SVH
`define ADCCTL_PARAMS_SVH

`define ADCCTL_OFS_CTRL_A      12'h000
`define ADCCTL_OFS_CTRL_B      12'h004
`define ADCCTL_OFS_PIN_SHARE   12'h008
`define ADCCTL_OFS_STATUS      12'h00C
`define ADCCTL_OFS_IRQ_EN      12'h010

`define ADCCTL_A_START_BIT     7
`define ADCCTL_A_BUSY_BIT      6
`define ADCCTL_A_POWER_BIT     5
`define ADCCTL_A_FORMAT_BIT    4
`define ADCCTL_A_CHAN_LSB      0
`define ADCCTL_B_INSRC_LSB     5
`define ADCCTL_B_REF_LSB       3
`define ADCCTL_B_DIV_LSB       0

`define ADCCTL_CTRL_A_RESET    8'h00
`define ADCCTL_CTRL_B_RESET    8'h00
`define ADCCTL_PIN_SHARE_RESET 4'h0

`define ADCCTL_SAMPLE_CYCLES   5'd4
`define ADCCTL_TOTAL_CYCLES    5'd16

`endif

// file: rtl/adcctl_pkg.sv
// Types shared by the converter control block.
// Assumes adcctl_params.svh holds the numeric constants.
package adcctl_pkg;
   typedef enum logic [1:0] {ADCCTL_SRC_EXT, ADCCTL_SRC_OPAMP, ADCCTL_SRC_DAC} adcctl_src_t;
   typedef enum logic [1:0] {ADCCTL_REF_PIN, ADCCTL_REF_SUPPLY, ADCCTL_REF_DAC} adcctl_ref_t;
   typedef enum logic [1:0] {ADCCTL_IDLE, ADCCTL_ARMED, ADCCTL_SAMPLE, ADCCTL_CONVERT} adcctl_state_t;
endpackage : adcctl_pkg

// file: rtl/adcctl_clock_div.sv
// Conversion clock divider: one-cycle tick at core_clk divided by 2**divSel.
// Assumes divSel stays stable during a conversion; the count restarts on clear.
`timescale 1ns/1ps
module adcctl_clock_div
(
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic       clear,
   input  wire logic [2:0] divSel,
   output logic            convTick
);
   logic [6:0] count_reg;
   logic [6:0] count_next;
   wire  [6:0] terminal = 7'((8'h01 << divSel) - 8'h01);
   wire        atEnd    = (count_reg == terminal);

   assign count_next = (clear || atEnd) ? 7'h00 : 7'(count_reg + 7'h01);
   // Code 000 ticks every cycle, code 111 every 128th.
   assign convTick   = atEnd && !clear;

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         count_reg <= 7'h00;
      else
         count_reg <= count_next;
   end
endmodule : adcctl_clock_div

// file: rtl/adcctl_conv_control.sv
// Converter control: APB registers, start sequencing, busy flag, request flag, input and reference routing.
// Assumes an APB master on core_clk; analog core, result data and interrupt controller lie outside.
//
// Overview of operation
// - Start pulse low-high-low begins a conversion.
// - Busy flag set while converting.
// - Busy flag clears when conversion ends.
// - Completion sets request flag; enable gates output.
// - Conversion clock is core clock over 2**sel.
// - Converter powered only while enable high.
// - Reference select: pin, supply, DAC reference.
// - Analog pin assignment disables digital functions.
// - Pull-high removed on analog pins.
// - Analog assignment overrides port direction.
// - Source codes 000,101-111 select external path.
// - Codes 001-011 op-amp, 100 DAC output.
// - Channel codes 0-3 connect pins, others float.
// - Sixteen conversion clocks: four sample, twelve convert.
`timescale 1ns/1ps
`include "adcctl_params.svh"
module adcctl_conv_control
(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [3:0]  portPullEnable,
   input  wire logic [3:0]  portOutputEnable,
   input  wire logic [3:0]  portDigitalOut,
   output logic             converterPowerEnable,
   output logic             convSampling,
   output logic             convConverting,
   output logic             convDone,
   output logic             convIrq,
   output logic [1:0]       referenceSourceSel,
   output logic             refFromPin,
   output logic             refFromSupply,
   output logic             refFromDac,
   output logic             srcOpamp0,
   output logic             srcOpamp1,
   output logic             srcOpamp2,
   output logic             srcDac,
   output logic [3:0]       channelConnect,
   output logic [3:0]       pinAnalogMode,
   output logic [3:0]       pinPullEnable,
   output logic [3:0]       pinOutputEnable,
   output logic [3:0]       pinDigitalOut,
   output logic             dataFormatSel
);
   // ************************************************************
   // Register bus
   // ************************************************************
   logic [7:0]  ctrlA_reg;
   logic [7:0]  ctrlB_reg;
   logic [3:0]  pinShare_reg;
   logic        irqFlag_reg;
   logic        irqEnable_reg;
   logic [31:0] prdata_reg;
   logic        busy_reg;

   wire access    = psel && penable;
   wire wrAccess  = access && pwrite;
   wire rdSetup   = psel && !penable && !pwrite;
   wire hitCtrlA  = (paddr == `ADCCTL_OFS_CTRL_A);
   wire hitCtrlB  = (paddr == `ADCCTL_OFS_CTRL_B);
   wire hitPin    = (paddr == `ADCCTL_OFS_PIN_SHARE);
   wire hitStatus = (paddr == `ADCCTL_OFS_STATUS);
   wire hitIrqEn  = (paddr == `ADCCTL_OFS_IRQ_EN);
   wire mapped    = hitCtrlA || hitCtrlB || hitPin || hitStatus || hitIrqEn;

   assign pready  = 1'b1;
   assign pslverr = access && !mapped;
   // Read data is captured as the setup cycle ends, so it stands in a flip-flop
   // for the whole access phase and the master can take it at the pready edge.
   // Status seen by a read is therefore one cycle old.
   assign prdata  = prdata_reg;

   // The busy bit is read-only; a write to it is ignored.
   wire [7:0] ctrlAView = {ctrlA_reg[7], busy_reg, ctrlA_reg[5:0]};
   logic [31:0] readMux;
   always_comb
   begin
      if (hitCtrlA)
         readMux = {24'h00_0000, ctrlAView};
      else if (hitCtrlB)
         readMux = {24'h00_0000, ctrlB_reg};
      else if (hitPin)
         readMux = {28'h000_0000, pinShare_reg};
      else if (hitStatus)
         readMux = {30'h0000_0000, busy_reg, irqFlag_reg};
      else if (hitIrqEn)
         readMux = {31'h0000_0000, irqEnable_reg};
      else
         readMux = 32'h0000_0000;
   end

   wire [7:0] ctrlA_next = wrAccess && hitCtrlA ? pwdata[7:0] : ctrlA_reg;
   wire [7:0] ctrlB_next = wrAccess && hitCtrlB ? pwdata[7:0] : ctrlB_reg;
   wire [3:0] pinShare_next = wrAccess && hitPin ? pwdata[3:0] : pinShare_reg;
   wire       irqEnable_next = wrAccess && hitIrqEn ? pwdata[0] : irqEnable_reg;

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         ctrlA_reg     <= `ADCCTL_CTRL_A_RESET;
         ctrlB_reg     <= `ADCCTL_CTRL_B_RESET;
         pinShare_reg  <= `ADCCTL_PIN_SHARE_RESET;
         irqEnable_reg <= 1'b0;
         prdata_reg    <= 32'h0000_0000;
      end
      else
      begin
         ctrlA_reg     <= ctrlA_next;
         ctrlB_reg     <= ctrlB_next;
         pinShare_reg  <= pinShare_next;
         irqEnable_reg <= irqEnable_next;
         prdata_reg    <= rdSetup ? readMux : prdata_reg;
      end
   end

   // ************************************************************
   // Field decode
   // ************************************************************
   wire       startBit  = ctrlA_reg[`ADCCTL_A_START_BIT];
   wire       powerOn   = ctrlA_reg[`ADCCTL_A_POWER_BIT];
   wire [3:0] chanSel   = ctrlA_reg[`ADCCTL_A_CHAN_LSB +: 4];
   wire [2:0] inputSel  = ctrlB_reg[`ADCCTL_B_INSRC_LSB +: 3];
   wire [1:0] refSel    = ctrlB_reg[`ADCCTL_B_REF_LSB +: 2];
   wire [2:0] divSel    = ctrlB_reg[`ADCCTL_B_DIV_LSB +: 3];

   // Clearing the power bit also aborts any conversion in the sequencer below.
   assign converterPowerEnable = powerOn;
   assign dataFormatSel        = ctrlA_reg[`ADCCTL_A_FORMAT_BIT];
   assign referenceSourceSel   = refSel;

   adcctl_pkg::adcctl_ref_t refKind;
   adcctl_pkg::adcctl_src_t srcKind;
   assign refKind = (refSel == 2'b01) ? adcctl_pkg::ADCCTL_REF_SUPPLY :
                    (refSel == 2'b10) ? adcctl_pkg::ADCCTL_REF_DAC : adcctl_pkg::ADCCTL_REF_PIN;
   assign refFromPin    = (refKind == adcctl_pkg::ADCCTL_REF_PIN);
   assign refFromSupply = (refKind == adcctl_pkg::ADCCTL_REF_SUPPLY);
   assign refFromDac    = (refKind == adcctl_pkg::ADCCTL_REF_DAC);

   assign srcKind = (inputSel == 3'b100) ? adcctl_pkg::ADCCTL_SRC_DAC :
                    (inputSel >= 3'b001 && inputSel <= 3'b011) ? adcctl_pkg::ADCCTL_SRC_OPAMP :
                    adcctl_pkg::ADCCTL_SRC_EXT;
   assign srcOpamp0 = (inputSel == 3'b001);
   assign srcOpamp1 = (inputSel == 3'b010);
   assign srcOpamp2 = (inputSel == 3'b011);
   assign srcDac    = (srcKind == adcctl_pkg::ADCCTL_SRC_DAC);

   // ************************************************************
   // Pin sharing
   // ************************************************************

   // The channel switch closes even for an internal source, so a wrong code
   // shorts a pin to the internal node; only software can prevent that.
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : gPin
         assign channelConnect[g]  = (chanSel == 4'(g));
         assign pinAnalogMode[g]   = pinShare_reg[g];
         assign pinPullEnable[g]   = portPullEnable[g] && !pinShare_reg[g];
         assign pinOutputEnable[g] = portOutputEnable[g] && !pinShare_reg[g];
         assign pinDigitalOut[g]   = portDigitalOut[g] && !pinShare_reg[g];
      end
   endgenerate

   // ************************************************************
   // Conversion sequencer
   // ************************************************************
   adcctl_pkg::adcctl_state_t state_reg;
   adcctl_pkg::adcctl_state_t state_next;
   logic       startPrev_reg;
   logic [4:0] tickCount_reg;
   logic [4:0] tickCount_next;
   logic       done_reg;
   logic       convTick;

   wire startRise = startBit && !startPrev_reg;
   wire startFall = !startBit && startPrev_reg;
   // The divider is held clear until sampling starts, so the first conversion
   // clock tick always lies a full period after the start pulse ends.
   wire divClear  = (state_reg == adcctl_pkg::ADCCTL_IDLE) || (state_reg == adcctl_pkg::ADCCTL_ARMED);

   adcctl_clock_div uClockDiv
   (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .clear    (divClear),
      .divSel   (divSel),
      .convTick (convTick)
   );

   // The sixteenth tick ends the conversion; the tick counter never reaches sixteen.
   wire lastTick = convTick && (tickCount_reg == `ADCCTL_TOTAL_CYCLES - 5'd1);

   // Power loss and a fresh start rise both abandon a conversion without a
   // completion, so software never sees a flag for an aborted result.
   always_comb
   begin
      state_next     = state_reg;
      tickCount_next = tickCount_reg;
      if (!powerOn)
      begin
         state_next     = adcctl_pkg::ADCCTL_IDLE;
         tickCount_next = 5'd0;
      end
      else if (startRise)
      begin
         state_next     = adcctl_pkg::ADCCTL_ARMED;
         tickCount_next = 5'd0;
      end
      else
      begin
         case (state_reg)
            adcctl_pkg::ADCCTL_IDLE:
               state_next = adcctl_pkg::ADCCTL_IDLE;
            // Armed waits for the start bit to drop; busy stays low until then.
            adcctl_pkg::ADCCTL_ARMED:
               if (startFall)
                  state_next = adcctl_pkg::ADCCTL_SAMPLE;
            adcctl_pkg::ADCCTL_SAMPLE:
               if (convTick)
               begin
                  tickCount_next = 5'(tickCount_reg + 5'd1);
                  if (tickCount_reg == `ADCCTL_SAMPLE_CYCLES - 5'd1)
                     state_next = adcctl_pkg::ADCCTL_CONVERT;
               end
            adcctl_pkg::ADCCTL_CONVERT:
               if (lastTick)
               begin
                  state_next     = adcctl_pkg::ADCCTL_IDLE;
                  tickCount_next = 5'd0;
               end
               else if (convTick)
                  tickCount_next = 5'(tickCount_reg + 5'd1);
            default:
               state_next = adcctl_pkg::ADCCTL_IDLE;
         endcase
      end
   end

   // ************************************************************
   // Status flags
   // ************************************************************

   wire doneNow = (state_reg == adcctl_pkg::ADCCTL_CONVERT) && lastTick && powerOn && !startRise;
   wire busy_next = (state_next == adcctl_pkg::ADCCTL_SAMPLE) || (state_next == adcctl_pkg::ADCCTL_CONVERT);
   // A completion in the clearing cycle wins over the write-one clear.
   wire irqClear = wrAccess && hitStatus && pwdata[0];
   wire irqFlag_next = doneNow || (irqFlag_reg && !irqClear);

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         state_reg     <= adcctl_pkg::ADCCTL_IDLE;
         startPrev_reg <= 1'b0;
         tickCount_reg <= 5'd0;
         busy_reg      <= 1'b0;
         irqFlag_reg   <= 1'b0;
         done_reg      <= 1'b0;
      end
      else
      begin
         state_reg     <= state_next;
         startPrev_reg <= startBit;
         tickCount_reg <= tickCount_next;
         busy_reg      <= busy_next;
         irqFlag_reg   <= irqFlag_next;
         done_reg      <= doneNow;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************

   assign convSampling   = (state_reg == adcctl_pkg::ADCCTL_SAMPLE);
   assign convConverting = (state_reg == adcctl_pkg::ADCCTL_CONVERT);
   assign convDone       = done_reg;
   assign convIrq        = irqFlag_reg && irqEnable_reg;
endmodule : adcctl_conv_control

// file: sim/adcctl_conv_control_sva.sv
// Checker for the converter control block: conversion timing, routing, interrupt gating, pin override.
// Assumes it is bound to adcctl_conv_control and sees only that module's ports.
`timescale 1ns/1ps
`include "adcctl_params.svh"
module adcctl_conv_control_sva
(
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  portPullEnable,
   input wire logic [3:0]  portOutputEnable,
   input wire logic [3:0]  pinAnalogMode,
   input wire logic [3:0]  pinPullEnable,
   input wire logic [3:0]  pinOutputEnable,
   input wire logic        converterPowerEnable,
   input wire logic        convSampling,
   input wire logic        convConverting,
   input wire logic        convDone,
   input wire logic        convIrq,
   input wire logic        srcOpamp0,
   input wire logic        srcOpamp1,
   input wire logic        srcOpamp2,
   input wire logic        srcDac,
   input wire logic [3:0]  channelConnect
);
   // ****************************************
   // Shadow state and assertions
   // ****************************************
   logic [15:0] smpCnt_reg;
   logic [15:0] cnvCnt_reg;
   logic [2:0]  div_reg;
   logic        irqEn_reg;
   wire         wrAcc  = psel && penable && pwrite;
   wire         wrA    = wrAcc && paddr == `ADCCTL_OFS_CTRL_A;
   wire         wrB    = wrAcc && paddr == `ADCCTL_OFS_CTRL_B;
   wire         wrIe   = wrAcc && paddr == `ADCCTL_OFS_IRQ_EN;
   wire  [15:0] smpLen = 16'h0004 << div_reg;
   wire  [15:0] cnvLen = 16'h000C << div_reg;

   // The divider shadow is only right while software leaves the code alone during a conversion.
   always_ff @(posedge core_clk)
   begin
      smpCnt_reg <= (rst_n && convSampling) ? smpCnt_reg + 16'h0001 : 16'h0000;
      cnvCnt_reg <= (rst_n && convConverting) ? cnvCnt_reg + 16'h0001 : 16'h0000;
      div_reg    <= !rst_n ? 3'h0 : (wrB ? pwdata[2:0] : div_reg);
      irqEn_reg  <= !rst_n ? 1'b0 : (wrIe ? pwdata[0] : irqEn_reg);
   end

   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   sequence sampleToConvert;
      $fell(convSampling) ##0 convConverting;
   endsequence

   AST_SAMPLE_LEN: assert property (sampleToConvert |-> smpCnt_reg == smpLen)
      else $error("sampling phase length wrong");
   AST_CONV_LEN: assert property (convDone |-> cnvCnt_reg == cnvLen || $past(cnvCnt_reg) == cnvLen)
      else $error("conversion phase length wrong");
   AST_POWER_OFF: assert property (!converterPowerEnable [*3] |-> !convSampling && !convConverting)
      else $error("converter active while powered off");
   AST_CHAN: assert property (wrA |=> channelConnect == ($past(pwdata[3:0]) < 4'h4 ? 4'h1 << $past(pwdata[1:0]) : 4'h0))
      else $error("channel connection wrong");
   AST_SRC: assert property (wrB |=> {srcDac, srcOpamp2, srcOpamp1, srcOpamp0} ==
      ($past(pwdata[7:5]) inside {[1:4]} ? 4'h1 << ($past(pwdata[7:5]) - 3'h1) : 4'h0))
      else $error("input source routing wrong");
   AST_PIN: assert property (pinPullEnable == (portPullEnable & ~pinAnalogMode)
      && pinOutputEnable == (portOutputEnable & ~pinAnalogMode))
      else $error("analog pin override wrong");
   AST_IRQ_GATE: assert property (!irqEn_reg |-> !convIrq)
      else $error("interrupt request while disabled");
   AST_IRQ_DONE: assert property (convDone && irqEn_reg |-> ##[0:1] convIrq)
      else $error("interrupt request missing at completion");
endmodule : adcctl_conv_control_sva

// file: sim/adcctl_conv_control_tb.sv
// Self-checking bench for the converter control block, driven over APB with a behavioural model.
// Assumes the design holds read data and pslverr valid through the access phase until pready.
`timescale 1ns/1ps
`include "adcctl_params.svh"
module adcctl_conv_control_tb;
   // ****************************************
   // Stimulus, model and checks
   // ****************************************
   localparam logic [11:0] RA = `ADCCTL_OFS_CTRL_A;
   localparam logic [11:0] RB = `ADCCTL_OFS_CTRL_B;
   localparam logic [11:0] RS = `ADCCTL_OFS_STATUS;
   localparam int          SETTLE = 8;
   logic        core_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000, prdata, rd;
   logic        pready, pslverr, converterPowerEnable, convSampling, convConverting, convDone, convIrq;
   logic        refFromPin, refFromSupply, refFromDac, srcOpamp0, srcOpamp1, srcOpamp2, srcDac, dataFormatSel;
   logic [1:0]  referenceSourceSel;
   logic [3:0]  portPullEnable = 4'h0, portOutputEnable = 4'h0, portDigitalOut = 4'h0, ps;
   logic [3:0]  channelConnect, pinAnalogMode, pinPullEnable, pinOutputEnable, pinDigitalOut;
   integer      err_count = 0, samples_checked = 0, seed = 32'h390d, i, n, d, ch;

   adcctl_conv_control dut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .portPullEnable, .portOutputEnable, .portDigitalOut, .converterPowerEnable, .convSampling,
      .convConverting, .convDone, .convIrq, .referenceSourceSel, .refFromPin, .refFromSupply, .refFromDac,
      .srcOpamp0, .srcOpamp1, .srcOpamp2, .srcDac, .channelConnect, .pinAnalogMode, .pinPullEnable,
      .pinOutputEnable, .pinDigitalOut, .dataFormatSel);

   initial forever #12.5 core_clk = ~core_clk;

   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
         err_count = err_count + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Read data is taken at the access edge where pready is sampled high; one idle edge follows.
   task apb(input logic [11:0] a, input logic w, input logic [31:0] dat);
      @(posedge core_clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= dat;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      er = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask : apb

   task start(input integer c);
      apb(RA, 1'b1, 32'h00a0 | c);
      apb(RA, 1'b1, 32'h0020 | c);
   endtask : start

   task wrap_up;
      $display("checks=%0d mismatches=%0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : wrap_up

   initial
   begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      for (i = 0; i < 5; i++)
      begin
         apb(i * 4, 1'b0, 32'h0000);
         chk(rd, 32'h0000);
      end
      apb(12'h020, 1'b0, 32'h0000);
      chk({pready, er}, 2'b11);
      chk(rd, 32'h0000_0000);
      apb(RA, 1'b1, 32'h0040);
      apb(RA, 1'b0, 32'h0000);
      chk(rd, 32'h0000);
      $display("register test done");
      for (i = 0; i < 16; i++)
      begin
         n = (i < 4) ? 0 : i % 8;
         ps = $random(seed);
         portPullEnable <= $random(seed);
         portOutputEnable <= $random(seed);
         portDigitalOut <= $random(seed);
         apb(RA, 1'b1, i | ((i & 1) << 4));
         apb(RB, 1'b1, (n << 5) | ((i % 4) << 3));
         apb(`ADCCTL_OFS_PIN_SHARE, 1'b1, ps);
         chk(channelConnect, (i < 4) ? 1 << i : 0);
         chk({srcDac, srcOpamp2, srcOpamp1, srcOpamp0}, (n >= 1 && n <= 4) ? 1 << (n - 1) : 0);
         chk({refFromDac, refFromSupply, refFromPin}, (i % 4 == 1) ? 2 : (i % 4 == 2) ? 4 : 1);
         chk({pinPullEnable, pinOutputEnable}, {portPullEnable & ~ps, portOutputEnable & ~ps});
         chk({pinDigitalOut, pinAnalogMode, referenceSourceSel, dataFormatSel},
             {portDigitalOut & ~ps, ps, 2'(i % 4), 1'(i & 1)});
      end
      apb(`ADCCTL_OFS_PIN_SHARE, 1'b1, 32'h000f);
      $display("routing test done");
      for (d = 0; d < 8; d++)
      begin
         ch = $random(seed) & 3;
         apb(`ADCCTL_OFS_IRQ_EN, 1'b1, d % 2);
         apb(RB, 1'b1, d);
         apb(RA, 1'b1, 32'h0020 | ch);
         chk(converterPowerEnable, 1'b1);
         repeat (SETTLE) @(posedge core_clk);
         start(ch);
         apb(RA, 1'b0, 32'h0000);
         chk(rd[7:0], 8'h60 | ch);
         n = 0;
         while (convDone !== 1'b1 && n < 4000)
         begin
            @(posedge core_clk);
            n = n + 1;
         end
         chk(n <= (16 << d) && n + 8 >= (16 << d), 1);
         @(posedge core_clk);
         chk(convIrq, d % 2);
         apb(RS, 1'b0, 32'h0000);
         chk(rd, 32'h0001);
         apb(RS, 1'b1, 32'h0001);
         apb(RS, 1'b0, 32'h0000);
         chk(rd, 32'h0000);
         if (d == 3)
         begin
            start(ch);
            repeat (20) @(posedge core_clk);
            apb(RA, 1'b1, 32'h00a0 | ch);
            repeat (150) @(posedge core_clk);
            apb(RS, 1'b0, 32'h0000);
            chk(rd, 32'h0000);
            apb(RA, 1'b1, 32'h0020 | ch);
            apb(RA, 1'b0, 32'h0000);
            chk(rd[7:0], 8'h60 | ch);
            repeat (20) @(posedge core_clk);
            apb(RA, 1'b1, 32'h0000);
            repeat (150) @(posedge core_clk);
            apb(RS, 1'b0, 32'h0000);
            chk(rd, 32'h0000);
         end
      end
      $display("conversion test done");
      wrap_up();
   end

   initial
   begin
      repeat (30000) @(posedge core_clk);
      err_count = err_count + 1;
      wrap_up();
   end
endmodule : adcctl_conv_control_tb

bind adcctl_conv_control adcctl_conv_control_sva chk_i (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
   .pwdata, .portPullEnable, .portOutputEnable, .pinAnalogMode, .pinPullEnable, .pinOutputEnable,
   .converterPowerEnable, .convSampling, .convConverting, .convDone, .convIrq, .srcOpamp0, .srcOpamp1,
   .srcOpamp2, .srcDac, .channelConnect);
